// *** rtl/pef_pkg.sv ***
// package for the port e / port f pin logic block
package pef_pkg;

  // ---------------------------------------------------------------
  // register offsets (plain register port, byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_DIR_E     = 4'h0;
  localparam logic [3:0] ADDR_PINS_E    = 4'h1;
  localparam logic [3:0] ADDR_LAT_E     = 4'h2;
  localparam logic [3:0] ADDR_MEM_CTL   = 4'h3;
  localparam logic [3:0] ADDR_SLV_CTL   = 4'h4;
  localparam logic [3:0] ADDR_DIR_F     = 4'h5;
  localparam logic [3:0] ADDR_PINS_F    = 4'h6;
  localparam logic [3:0] ADDR_LAT_F     = 4'h7;
  localparam logic [3:0] ADDR_ANA_CFG   = 4'h8;
  localparam logic [3:0] ADDR_CMP_CTL   = 4'h9;
  localparam logic [3:0] ADDR_CVR_CTL   = 4'hA;
  localparam logic [3:0] ADDR_MODE_CTL  = 4'hB;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EXT_BUS_OFF_BIT   = 7;  // memory_bus_control
  localparam int SLAVE_PORT_ON_BIT = 4;  // slave_port_control
  localparam int CVR_OE_BIT        = 6;  // comparator_ref_control
  localparam int MODE_MCU_BIT      = 0;  // mode: microcontroller mode
  localparam int MODE_CCP_ALT_BIT  = 1;  // mode: bit 7 as capture_compare_two
  localparam int MODE_SS_BIT       = 2;  // mode: f bit 7 slave select
  localparam int MODE_C1OE_BIT     = 3;  // mode: drive cmp1 on f bit 2
  localparam int MODE_C2OE_BIT     = 4;  // mode: drive cmp2 on f bit 1
  localparam int RD_BIT            = 0;
  localparam int WR_BIT            = 1;
  localparam int CS_BIT            = 2;
  localparam int CMP_MODE_W        = 3;

  // ---------------------------------------------------------------
  // reset values and decode constants
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DIR        = 8'hFF;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_MEM_CTL    = 8'h00;
  localparam logic [2:0] CMP_OFF_MODE   = 3'h7;
  localparam logic [3:0] ANA_ALL_DIGITAL= 4'hF;
  localparam logic [7:0] MEM_CTL_MASK   = 8'hB3;
  localparam logic [7:0] SLV_CTL_MASK   = 8'h10;
  localparam logic [7:0] ANA_CFG_MASK   = 8'h3F;
  localparam logic [7:0] MODE_MASK      = 8'h1F;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pef_pin_drive_type;

  typedef struct packed {
    logic       rd_pulse;   // parallel slave read of port d
    logic       wr_pulse;   // parallel slave write of port d
    logic       selected;
  } pef_psp_type;

  typedef struct packed {
    logic [7:0] dir_e;
    logic [7:0] lat_e;
    logic [7:0] mem_ctl;
    logic [7:0] slv_ctl;
    logic [7:0] dir_f;
    logic [7:0] lat_f;
    logic [7:0] ana_cfg;
    logic [7:0] cmp_ctl;
    logic [7:0] cvr_ctl;
    logic [7:0] mode;
    logic [7:0] rdata;
    logic [2:0] psp_prev;   // last rd/wr/cs levels
    logic       psp_rd;
    logic       psp_wr;
  } pef_state_type;

endpackage

// *** rtl/pef_port_ef.sv ***
// port e / port f pin logic with register port
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps

module pef_port_ef
  import pef_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       clk_en_i,
  // register port
  input  wire logic [3:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [7:0]                 reg_rdata_o,
  // port e pins
  input  wire logic [7:0]                 pin_e_i,
  output logic      [7:0]                 pin_e_o,
  output logic      [7:0]                 pin_e_oe_o,
  output logic      [7:0]                 pin_e_ttl_o,
  // port f pins
  input  wire logic [7:0]                 pin_f_i,
  output logic      [7:0]                 pin_f_o,
  output logic      [7:0]                 pin_f_oe_o,
  output logic      [7:0]                 pin_f_ttl_o,
  // external bus high byte
  input  wire logic [7:0]                 ext_ad_hi_i,
  input  wire logic                       ext_ad_oe_i,
  output logic      [7:0]                 ext_ad_hi_o,
  // capture/compare two
  input  wire logic                       capture_compare_two_out_i,
  input  wire logic                       capture_compare_two_oe_i,
  output logic                            capture_compare_two_in_o,
  // comparators and reference
  input  wire logic                       comparator_one_result_i,
  input  wire logic                       comparator_two_result_i,
  input  wire logic                       comparator_ref_output_i,
  output logic                            serial_slave_select_o,
  // parallel slave port strobes
  output pef_pkg::pef_psp_type            psp_o,
  output logic                            f_digital_o
);
  import pef_pkg::*;

  pef_state_type st_ff;
  pef_state_type nxt_st;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  logic ext_bus_on;
  logic slave_on;
  logic f_digital;
  logic ccp_on;
  logic c1_on;
  logic c2_on;
  logic cvr_on;
  logic ss_on;

  // bus owns port e unless disabled by software
  assign ext_bus_on = ~st_ff.mem_ctl[EXT_BUS_OFF_BIT]
                      & ~st_ff.mode[MODE_MCU_BIT];
  assign slave_on   = st_ff.slv_ctl[SLAVE_PORT_ON_BIT];
  // digital f only with comparators off and pins digital
  assign f_digital  = (st_ff.cmp_ctl[CMP_MODE_W-1:0] == CMP_OFF_MODE)
                      & (st_ff.ana_cfg[3:0] == ANA_ALL_DIGITAL);
  assign ccp_on     = st_ff.mode[MODE_MCU_BIT]
                      & st_ff.mode[MODE_CCP_ALT_BIT];
  assign c1_on      = st_ff.mode[MODE_C1OE_BIT];
  assign c2_on      = st_ff.mode[MODE_C2OE_BIT];
  assign cvr_on     = st_ff.cvr_ctl[CVR_OE_BIT];
  assign ss_on      = st_ff.mode[MODE_SS_BIT];

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  function automatic pef_pin_drive_type io_drive(
    input logic [7:0] lat,
    input logic [7:0] dir
  );
    pef_pin_drive_type d;
    d.out = lat;
    d.oe  = ~dir;
    return d;
  endfunction

  pef_pin_drive_type drv_e;
  pef_pin_drive_type drv_f;

  // port e: io, bus, capture_compare_two and slave strobe overrides
  always_comb begin
    drv_e = io_drive(st_ff.lat_e, st_ff.dir_e);
    if (ext_bus_on) begin
      drv_e.out = ext_ad_hi_i;
      drv_e.oe  = {8{ext_ad_oe_i}};
    end else begin
      if (slave_on) begin
        drv_e.oe[CS_BIT:RD_BIT] = 3'h0;
      end
      if (ccp_on) begin
        drv_e.out[7] = capture_compare_two_out_i;
        drv_e.oe[7]  = capture_compare_two_oe_i;
      end
    end
  end

  // port f: io plus comparator and reference outputs
  always_comb begin
    drv_f = io_drive(st_ff.lat_f, st_ff.dir_f);
    if (!f_digital) begin
      drv_f.oe[6:0] = 7'h00;
    end
    if (c2_on) begin
      drv_f.out[1] = comparator_two_result_i;
      drv_f.oe[1]  = 1'b1;
    end
    if (c1_on) begin
      drv_f.out[2] = comparator_one_result_i;
      drv_f.oe[2]  = 1'b1;
    end
    if (cvr_on) begin
      drv_f.out[5] = comparator_ref_output_i;
      drv_f.oe[5]  = 1'b1;
    end
    if (ss_on) begin
      drv_f.oe[7] = 1'b0;
    end
  end

  assign pin_e_o    = drv_e.out;
  assign pin_e_oe_o = drv_e.oe;
  assign pin_f_o    = drv_f.out;
  assign pin_f_oe_o = drv_f.oe;

  // buffer type select: ttl in bus, slave strobe or f bit 7 slave select use
  assign pin_e_ttl_o = ext_bus_on ? 8'hFF
                     : (slave_on ? 8'h07 : 8'h00);
  assign pin_f_ttl_o = {ss_on, 7'h00};

  // pin read paths; analog pins read zero
  logic [7:0] f_read;
  assign f_read = f_digital ? pin_f_i
                            : {pin_f_i[7], 7'h00};
  assign ext_ad_hi_o               = pin_e_i;
  assign capture_compare_two_in_o  = ccp_on & pin_e_i[7];
  assign serial_slave_select_o     = ss_on ? pin_f_i[7] : 1'b1;
  assign f_digital_o               = f_digital;

  // ---------------------------------------------------------------
  // parallel slave strobes
  // ---------------------------------------------------------------
  logic psp_sel;
  logic psp_rd_lvl;
  logic psp_wr_lvl;
  assign psp_sel    = slave_on & ~ext_bus_on
                      & ~pin_e_i[CS_BIT];
  assign psp_rd_lvl = psp_sel & ~pin_e_i[RD_BIT];
  assign psp_wr_lvl = psp_sel & ~pin_e_i[WR_BIT];

  assign psp_o.selected = psp_sel;
  assign psp_o.rd_pulse = st_ff.psp_rd;
  assign psp_o.wr_pulse = st_ff.psp_wr;
  assign reg_rdata_o    = st_ff.rdata;

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  function automatic logic [7:0] read_mux(
    input pef_state_type s,
    input logic [3:0]    a,
    input logic [7:0]    pe,
    input logic [7:0]    pf
  );
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_DIR_E:    r = s.dir_e;
      ADDR_PINS_E:   r = pe;
      ADDR_LAT_E:    r = s.lat_e;
      ADDR_MEM_CTL:  r = s.mem_ctl & MEM_CTL_MASK;
      ADDR_SLV_CTL:  r = s.slv_ctl & SLV_CTL_MASK;
      ADDR_DIR_F:    r = s.dir_f;
      ADDR_PINS_F:   r = pf;
      ADDR_LAT_F:    r = s.lat_f;
      ADDR_ANA_CFG:  r = s.ana_cfg & ANA_CFG_MASK;
      ADDR_CMP_CTL:  r = s.cmp_ctl;
      ADDR_CVR_CTL:  r = s.cvr_ctl;
      ADDR_MODE_CTL: r = s.mode & MODE_MASK;
      default:       r = 8'h00;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // strobe pulses on falling edge of selected rd/wr
    nxt_st.psp_prev = {psp_sel, psp_wr_lvl, psp_rd_lvl};
    nxt_st.psp_rd   = psp_rd_lvl & ~st_ff.psp_prev[0];
    nxt_st.psp_wr   = psp_wr_lvl & ~st_ff.psp_prev[1];
    nxt_st.rdata    = reg_rd_i
                      ? read_mux(st_ff, reg_addr_i, pin_e_i, f_read)
                      : 8'h00;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_DIR_E:    nxt_st.dir_e   = reg_wdata_i;
        ADDR_PINS_E,
        ADDR_LAT_E:    nxt_st.lat_e   = reg_wdata_i;
        ADDR_MEM_CTL:  nxt_st.mem_ctl = reg_wdata_i & MEM_CTL_MASK;
        ADDR_SLV_CTL:  nxt_st.slv_ctl = reg_wdata_i & SLV_CTL_MASK;
        ADDR_DIR_F:    nxt_st.dir_f   = reg_wdata_i;
        ADDR_PINS_F,
        ADDR_LAT_F:    nxt_st.lat_f   = reg_wdata_i;
        ADDR_ANA_CFG:  nxt_st.ana_cfg = reg_wdata_i & ANA_CFG_MASK;
        ADDR_CMP_CTL:  nxt_st.cmp_ctl = reg_wdata_i;
        ADDR_CVR_CTL:  nxt_st.cvr_ctl = reg_wdata_i;
        ADDR_MODE_CTL: nxt_st.mode    = reg_wdata_i & MODE_MASK;
        default:       nxt_st.mode    = st_ff.mode;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register, frozen while clock enable low
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff.dir_e    <= RST_DIR;
      st_ff.lat_e    <= RST_ZERO;
      st_ff.mem_ctl  <= RST_MEM_CTL;
      st_ff.slv_ctl  <= RST_ZERO;
      st_ff.dir_f    <= RST_DIR;
      st_ff.lat_f    <= RST_ZERO;
      st_ff.ana_cfg  <= RST_ZERO;
      st_ff.cmp_ctl  <= RST_ZERO;
      st_ff.cvr_ctl  <= RST_ZERO;
      st_ff.mode     <= RST_ZERO;
      st_ff.rdata    <= RST_ZERO;
      st_ff.psp_prev <= 3'h0;
      st_ff.psp_rd   <= 1'b0;
      st_ff.psp_wr   <= 1'b0;
    end else if (clk_en_i) begin
      st_ff <= nxt_st;
    end
  end

endmodule

// *** sim/pef_port_ef_asserts.sv ***
// concurrent checks for the port e / port f pin logic
`timescale 1ns/1ps
module pef_port_ef_asserts (
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic [7:0]          pin_e_i,
  input  wire logic [7:0]          pin_f_i,
  input  wire logic [7:0]          pin_f_oe_o,
  input  wire logic [7:0]          ext_ad_hi_o,
  input  wire logic                capture_compare_two_in_o,
  input  wire logic                serial_slave_select_o,
  input  wire logic                f_digital_o,
  input  wire pef_pkg::pef_psp_type psp_o
);
  import pef_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // -------------------------------------------------------------
  // pin and strobe relations
  // -------------------------------------------------------------
  property p_f0_dig;
    pin_f_oe_o[0] |-> f_digital_o;
  endproperty
  a_f0_dig: assert property (p_f0_dig) else $error("f0 driven");
  property p_sel_cs;
    psp_o.selected |-> !pin_e_i[2];
  endproperty
  a_sel_cs: assert property (p_sel_cs) else $error("bad select");
  property p_rd_rise;
    $rose(psp_o.selected && !pin_e_i[0]) |=> psp_o.rd_pulse;
  endproperty
  a_rd_rise: assert property (p_rd_rise) else $error("no rd");
  property p_rd_cause;
    psp_o.rd_pulse |-> $past(psp_o.selected && !pin_e_i[0]) ##1 !psp_o.rd_pulse;
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("rd");
  property p_wr_rise;
    $rose(psp_o.selected && !pin_e_i[1]) |=> psp_o.wr_pulse;
  endproperty
  a_wr_rise: assert property (p_wr_rise) else $error("no wr");
  property p_wr_cause;
    psp_o.wr_pulse |-> $past(psp_o.selected && !pin_e_i[1]) ##1 !psp_o.wr_pulse;
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("wr");
  property p_ss;
    !serial_slave_select_o |-> !pin_f_i[7];
  endproperty
  a_ss: assert property (p_ss) else $error("slave select");
  property p_ccp;
    capture_compare_two_in_o |-> pin_e_i[7];
  endproperty
  a_ccp: assert property (p_ccp) else $error("capture input");
  property p_bus_rd;
    ext_ad_hi_o == pin_e_i;
  endproperty
  a_bus_rd: assert property (p_bus_rd) else $error("bus read");
endmodule

bind pef_port_ef pef_port_ef_asserts u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .pin_e_i(pin_e_i),
  .pin_f_i(pin_f_i), .pin_f_oe_o(pin_f_oe_o), .ext_ad_hi_o(ext_ad_hi_o),
  .capture_compare_two_in_o(capture_compare_two_in_o),
  .serial_slave_select_o(serial_slave_select_o),
  .f_digital_o(f_digital_o), .psp_o(psp_o)
);

// *** sim/pef_pin_partner.sv ***
// pin-side model: outside drivers and wire resolution for ports e and f
`timescale 1ns/1ps
module pef_pin_partner (
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_e_o,
  input  wire logic [7:0] pin_e_oe_o,
  input  wire logic [7:0] pin_f_o,
  input  wire logic [7:0] pin_f_oe_o,
  input  wire logic [7:0] e_drv_i,
  input  wire logic [7:0] e_en_i,
  input  wire logic [7:0] f_drv_i,
  output logic      [7:0] wire_e_o,
  output logic      [7:0] wire_f_o
);
  logic [7:0] float_ff = 8'h5A;
  // undriven lines wander so a stale level never passes
  always_ff @(posedge clk_i) begin
    float_ff <= ~float_ff;
  end
  // device drive where enabled, else the outside, else floating on port e only; port f always takes the outside
  assign wire_e_o = (pin_e_oe_o & pin_e_o) | (~pin_e_oe_o &
                    ((e_en_i & e_drv_i) | (~e_en_i & float_ff)));
  assign wire_f_o = (pin_f_oe_o & pin_f_o) | (~pin_f_oe_o & f_drv_i);
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the port e / port f pin logic
`timescale 1ns/1ps
module tb_top;
  import pef_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic [7:0]  e_drv = 8'hFF;
  logic [7:0]  e_en = 8'h00;
  logic [7:0]  f_drv = 8'hC3;
  logic [7:0]  ext_hi = 8'hA5;
  logic        ext_oe = 1'b1;
  logic [4:0]  misc = 5'h13;
  logic [7:0]  lf = 8'h63;
  logic [7:0]  rdata, pe_o, pe_oe, pf_o, pf_oe, pe_in, pf_in;
  logic [7:0]  e_ttl;
  logic [7:0]  exp_q[$];
  pef_psp_type psp;
  int          err_count = 0;
  int          num_checks = 0;
  int          n_rd = 0;
  int          n_wr = 0;
  logic [3:0]  rst_a[8] = '{4'h0, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC};
  logic [7:0]  rst_v[8] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h00};

  pef_port_ef DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .pin_e_i(pe_in), .pin_e_o(pe_o), .pin_e_oe_o(pe_oe),
    .pin_e_ttl_o(e_ttl), .pin_f_i(pf_in), .pin_f_o(pf_o), .pin_f_oe_o(pf_oe),
    .pin_f_ttl_o(), .ext_ad_hi_i(ext_hi), .ext_ad_oe_i(ext_oe),
    .ext_ad_hi_o(), .capture_compare_two_out_i(misc[0]),
    .capture_compare_two_oe_i(misc[1]), .capture_compare_two_in_o(),
    .comparator_one_result_i(misc[2]), .comparator_two_result_i(misc[3]),
    .comparator_ref_output_i(misc[4]), .serial_slave_select_o(),
    .psp_o(psp), .f_digital_o());
  pef_pin_partner u_far (.clk_i(clk_i), .pin_e_o(pe_o), .pin_e_oe_o(pe_oe),
    .pin_f_o(pf_o), .pin_f_oe_o(pf_oe), .e_drv_i(e_drv), .e_en_i(e_en),
    .f_drv_i(f_drv), .wire_e_o(pe_in), .wire_f_o(pf_in));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(posedge clk_i);
  endtask
  // host strobe: select, strobe low, release
  task automatic psp_pulse(input logic [7:0] v);
    e_drv <= v | 8'h03;
    repeat (2) @(posedge clk_i);
    e_drv <= v;
    repeat (3) @(posedge clk_i);
    e_drv <= v | 8'h03;
    repeat (2) @(posedge clk_i);
    e_drv <= 8'hFF;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // wandering side inputs and strobe pulse counting
  always @(posedge clk_i) begin
    misc <= {misc[3:0], misc[4] ^ misc[2]};
    rd_q <= rd;
    if (psp.rd_pulse === 1'b1) n_rd++;
    if (psp.wr_pulse === 1'b1) n_wr++;
  end
  // read data stands in the cycle after the strobe
  always @(negedge clk_i) begin
    if (rd_q) chk("read data", exp_q.pop_front(), rdata);
  end
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (rst_a[i]) rd_reg(rst_a[i], rst_v[i]);
    rd_reg(ADDR_PINS_F, {f_drv[7], 7'h00});
    rd_reg(ADDR_PINS_E, 8'hA5);
    chk("e buffers bus", 8'hFF, e_ttl);
    $display("test reset and bus mode done");
    ext_oe <= 1'b0;
    wr_reg(ADDR_MEM_CTL, 8'h80);
    wr_reg(ADDR_MODE_CTL, 8'h01);
    wr_reg(ADDR_CMP_CTL, 8'h07);
    wr_reg(ADDR_ANA_CFG, 8'h0F);
    rd_reg(ADDR_MEM_CTL, 8'h80);
    for (int k = 0; k < 4; k++) begin
      lf = lfsr_next(lf);
      wr_reg(ADDR_PINS_E, lf);
      rd_reg(ADDR_LAT_E, lf);
      wr_reg(ADDR_DIR_E, 8'h00);
      rd_reg(ADDR_PINS_E, lf);
      wr_reg(ADDR_DIR_E, 8'hFF);
      e_drv <= ~lf;
      e_en <= 8'hFF;
      rd_reg(ADDR_PINS_E, ~lf);
      wr_reg(ADDR_LAT_F, lf ^ 8'h3C);
      rd_reg(ADDR_LAT_F, lf ^ 8'h3C);
      wr_reg(ADDR_PINS_F, lf);
      wr_reg(ADDR_DIR_F, 8'h00);
      rd_reg(ADDR_PINS_F, lf);
      wr_reg(ADDR_DIR_F, 8'hFF);
      f_drv <= ~lf;
      rd_reg(ADDR_PINS_F, ~lf);
      rd_reg(ADDR_LAT_F, lf);
    end
    $display("test port io done");
    wr_reg(ADDR_SLV_CTL, 8'h10);
    rd_reg(ADDR_SLV_CTL, 8'h10);
    chk("e buffers slave", 8'h07, e_ttl);
    psp_pulse(8'hFA);
    psp_pulse(8'hF9);
    psp_pulse(8'hFE);
    psp_pulse(8'hFD);
    chk("read pulses", 8'h01, 8'(n_rd));
    chk("write pulses", 8'h01, 8'(n_wr));
    $display("test slave strobes done");
    print_verdict();
  end
endmodule
